// *** hdl/ltc_pkg.sv ***
// shared constants and types for the line transmit configuration register bank
package ltc_pkg;
  localparam int LTC_CHANNELS = 8;
  localparam int LTC_AW = 14;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_IRQ_CHAN = 12'h009;
  localparam logic [11:0] IDX_TMR_EN = 12'h00c;
  localparam logic [11:0] IDX_TMR_STAT = 12'h00d;
  // per channel page: index bits 11:8 hold channel number plus one
  localparam logic [7:0] IDX_LINE_STD = 8'h20;
  localparam logic [7:0] IDX_ATT_CFG = 8'h21;
  localparam logic [7:0] IDX_TX_CFG0 = 8'h22;
  localparam logic [7:0] IDX_JIT_MEAS = 8'h2e;
  localparam logic [3:0] PAGE_GLOBAL = 4'h0;
  localparam logic [3:0] PAGE_FIRST = 4'h1;
  localparam logic [3:0] PAGE_LAST = 4'h8;
  // field positions
  localparam int TMR_BIT = 0;
  localparam int LSTD_BIT = 0;
  localparam int MEAS_BIT = 5;
  localparam int LIMIT_BIT = 4;
  localparam int ATT_EN_BIT = 3;
  localparam int DEPTH_LO = 1;
  localparam int BW_BIT = 0;
  localparam int TXOFF_BIT = 4;
  localparam int INV_BIT = 3;
  localparam int EDGE_BIT = 2;
  localparam int MODE_LO = 0;
  // reset values
  localparam logic [7:0] ATT_CFG_RST = 8'h10;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // one second timer
  localparam int TIMER_PERIOD_MS = 1000;
  localparam int CLOCK_KHZ = 200000;
  localparam int SEC_CYCLES = TIMER_PERIOD_MS * CLOCK_KHZ;
  // elastic store depth in bits and transfer corner in centi-hertz
  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] DEPTH_64 = 8'h40;
  localparam logic [7:0] DEPTH_32 = 8'h20;
  localparam logic [15:0] CORNER_T1_NARROW = 16'h01f4;
  localparam logic [15:0] CORNER_E1_NARROW = 16'h02a5;
  localparam logic [15:0] CORNER_T1_WIDE = 16'h007e;
  localparam logic [15:0] CORNER_E1_WIDE = 16'h0057;
  localparam logic [1:0] MODE_ZSUB = 2'b00;
  localparam logic [1:0] MODE_AMI = 2'b01;
  typedef enum logic [3:0] {
    ENC_HDB3 = 4'b0001,
    ENC_B8ZS = 4'b0010,
    ENC_AMI = 4'b0100,
    ENC_BYPASS = 4'b1000
  } ltc_enc_t;
  typedef struct packed {
    logic lineStandardBit;
    logic jitterMeasureMode;
    logic wideBandLimit;
    logic txAttenuatorEnable;
    logic [1:0] txAttenuatorDepth;
    logic txAttenuatorBandwidth;
    logic txOff;
    logic txDataPolarity;
    logic txSampleEdgeSelect;
    logic [1:0] txEncoderMode;
  } ltc_ch_cfg_t;
  typedef struct packed {
    ltc_enc_t encoder;
    logic powerDown;
    logic driverOe;
    logic invert;
    logic riseEdge;
    logic dualRail;
    logic attenInPath;
    logic wideLimit;
    logic lineT1;
    logic [7:0] depthBits;
    logic [15:0] cornerCentiHz;
  } ltc_tx_ctrl_t;
  typedef struct packed {
    logic hit;
    logic isChan;
    logic [7:0] low;
    logic [2:0] ch;
  } ltc_dec_t;
endpackage

// *** hdl/ltc_regs.sv ***
// register bank, one second timer interrupt and transmit front end for eight channels
//
// Overview of operation
// RQ1 - channel n+1 interrupt sets flag bit n
// RQ2 - timer interrupt forwarded only when enable set
// RQ3 - one second elapse sets overflow flag
// RQ4 - writing one clears overflow flag
// RQ5 - mode bit zero E1, one T1/J1
// RQ6 - jitter value live or peak-to-peak since read
// RQ7 - wide band limit bit, resets to one
// RQ8 - attenuator bypassed unless enable bit set
// RQ9 - depth 00=128, 01=64, else 32 bits
// RQ10 - bandwidth bit picks transfer corner per standard
// RQ11 - power down stops transmitter, driver high impedance
// RQ12 - polarity bit inverts incoming transmit data
// RQ13 - sample edge falling at zero, rising at one
// RQ14 - mode field picks encoder and rail format
// RQ15 - substitution encoder HDB3 for E1, B8ZS T1
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module ltc_regs import ltc_pkg::*; #(
  parameter int SecCycles = SEC_CYCLES,
  parameter int Channels = LTC_CHANNELS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [LTC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [Channels-1:0] chanIrq,
  input wire logic [Channels-1:0][7:0] jitSample,
  input wire logic [Channels-1:0] jitValid,
  input wire logic [Channels-1:0] txChannelClock,
  input wire logic [Channels-1:0] txSingleRailIn,
  input wire logic [Channels-1:0] txPositiveRailIn,
  input wire logic [Channels-1:0] txNegativeRailIn,
  output logic irq,
  output ltc_tx_ctrl_t [Channels-1:0] txCtrl,
  output logic [Channels-1:0] txPosRail,
  output logic [Channels-1:0] txNegRail,
  output logic [Channels-1:0] txBitStrobe
);

  // address decode shared by setup and access phases
  function automatic ltc_dec_t decode(input logic [LTC_AW-1:0] a);
    ltc_dec_t d;
    logic [11:0] idx;
    idx = a[LTC_AW-1:2];
    d.hit = 1'b0;
    d.isChan = 1'b0;
    d.low = idx[7:0];
    d.ch = 3'(idx[11:8] - PAGE_FIRST);
    if (a[1:0] == 2'b00) begin
      if (idx[11:8] == PAGE_GLOBAL) begin
        d.hit = (idx == IDX_IRQ_CHAN) || (idx == IDX_TMR_EN) || (idx == IDX_TMR_STAT);
      end else if (idx[11:8] >= PAGE_FIRST && idx[11:8] <= PAGE_LAST) begin
        d.isChan = 1'b1;
        d.hit = (d.low == IDX_LINE_STD) || (d.low == IDX_ATT_CFG) ||
                (d.low == IDX_TX_CFG0) || (d.low == IDX_JIT_MEAS);
      end
    end
    return d;
  endfunction

  // one-hot encoder choice from mode field and line standard
  function automatic ltc_enc_t pickEncoder(input ltc_ch_cfg_t c);
    ltc_enc_t e;
    if (c.txEncoderMode == MODE_ZSUB) begin
      e = c.lineStandardBit ? ENC_B8ZS : ENC_HDB3; // RQ15 RQ5
    end else if (c.txEncoderMode == MODE_AMI) begin
      e = ENC_AMI; // RQ14
    end else begin
      e = ENC_BYPASS; // RQ14
    end
    return e;
  endfunction

  ltc_dec_t dec;
  logic accessDone;
  logic wrEn;
  logic rdEn;
  logic [7:0] wbyte;
  logic [7:0] irqSourceChannelFlags_r;
  logic secondTimerIrqEnable_r;
  logic secondTimerOverflowFlag_r;
  logic [31:0] secCount_r;
  logic secTick;
  ltc_ch_cfg_t cfg_r [Channels];
  logic [7:0] jitValue_r [Channels];
  logic [7:0] jitMin_r [Channels];
  logic [7:0] jitMax_r [Channels];
  logic [Channels-1:0] jitEmpty_r;
  logic [Channels-1:0] clkMeta_r;
  logic [Channels-1:0] clkSync_r;
  logic [Channels-1:0] clkPrev_r;
  logic [Channels-1:0][2:0] dataMeta_r;
  logic [Channels-1:0][2:0] dataSync_r;
  assign dec = decode(paddr);
  assign accessDone = psel && penable && pready;
  assign wrEn = accessDone && pwrite && !pslverr && pstrb[0];
  assign rdEn = accessDone && !pwrite && !pslverr;
  assign wbyte = pwdata[7:0];
  assign secTick = (secCount_r == 32'(SecCycles - 1));
  // bus answer: no wait states, data and error latched in the setup cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !dec.hit;
        prdata <= 32'h0000_0000;
        if (dec.hit && !dec.isChan) begin
          case (paddr[LTC_AW-1:2])
            IDX_IRQ_CHAN: prdata[7:0] <= irqSourceChannelFlags_r;
            IDX_TMR_EN: prdata[TMR_BIT] <= secondTimerIrqEnable_r;
            IDX_TMR_STAT: prdata[TMR_BIT] <= secondTimerOverflowFlag_r;
            default: prdata <= 32'h0000_0000;
          endcase
        end else if (dec.hit) begin
          case (dec.low)
            IDX_LINE_STD: prdata[LSTD_BIT] <= cfg_r[dec.ch].lineStandardBit;
            IDX_ATT_CFG: begin
              prdata[MEAS_BIT] <= cfg_r[dec.ch].jitterMeasureMode;
              prdata[LIMIT_BIT] <= cfg_r[dec.ch].wideBandLimit;
              prdata[ATT_EN_BIT] <= cfg_r[dec.ch].txAttenuatorEnable;
              prdata[DEPTH_LO+:2] <= cfg_r[dec.ch].txAttenuatorDepth;
              prdata[BW_BIT] <= cfg_r[dec.ch].txAttenuatorBandwidth;
            end
            IDX_TX_CFG0: begin
              prdata[TXOFF_BIT] <= cfg_r[dec.ch].txOff;
              prdata[INV_BIT] <= cfg_r[dec.ch].txDataPolarity;
              prdata[EDGE_BIT] <= cfg_r[dec.ch].txSampleEdgeSelect;
              prdata[MODE_LO+:2] <= cfg_r[dec.ch].txEncoderMode;
            end
            IDX_JIT_MEAS: prdata[7:0] <= jitValue_r[dec.ch];
            default: prdata <= 32'h0000_0000;
          endcase
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // channel interrupt indication follows each channel request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irqSourceChannelFlags_r <= ZERO_RST; // RQ1
    end else begin
      irqSourceChannelFlags_r <= 8'(chanIrq); // RQ1
    end
  end

  // free running one second timer
  always_ff @(posedge clock) begin
    if (!rst_n || secTick) begin
      secCount_r <= 32'h0000_0000;
    end else begin
      secCount_r <= secCount_r + 32'h0000_0001;
    end
  end

  // timer enable and sticky overflow flag; a new overflow beats the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      secondTimerIrqEnable_r <= 1'b0;
      secondTimerOverflowFlag_r <= 1'b0;
    end else begin
      if (wrEn && !dec.isChan && paddr[LTC_AW-1:2] == IDX_TMR_EN) begin
        secondTimerIrqEnable_r <= wbyte[TMR_BIT];
      end
      if (secTick) begin
        secondTimerOverflowFlag_r <= 1'b1; // RQ3
      end else if (wrEn && !dec.isChan && paddr[LTC_AW-1:2] == IDX_TMR_STAT &&
                   wbyte[TMR_BIT]) begin
        secondTimerOverflowFlag_r <= 1'b0; // RQ4
      end
    end
  end

  // level interrupt, masked by the enable bit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= secondTimerOverflowFlag_r && secondTimerIrqEnable_r; // RQ2 RQ3
    end
  end

  // per channel configuration writes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < Channels; i++) begin
        cfg_r[i] <= '0;
        cfg_r[i].wideBandLimit <= ATT_CFG_RST[LIMIT_BIT]; // RQ7
      end
    end else if (wrEn && dec.isChan) begin
      case (dec.low)
        IDX_LINE_STD: cfg_r[dec.ch].lineStandardBit <= wbyte[LSTD_BIT]; // RQ5
        IDX_ATT_CFG: begin
          cfg_r[dec.ch].jitterMeasureMode <= wbyte[MEAS_BIT];
          cfg_r[dec.ch].wideBandLimit <= wbyte[LIMIT_BIT];
          cfg_r[dec.ch].txAttenuatorEnable <= wbyte[ATT_EN_BIT];
          cfg_r[dec.ch].txAttenuatorDepth <= wbyte[DEPTH_LO+:2];
          cfg_r[dec.ch].txAttenuatorBandwidth <= wbyte[BW_BIT];
        end
        IDX_TX_CFG0: begin
          cfg_r[dec.ch].txOff <= wbyte[TXOFF_BIT];
          cfg_r[dec.ch].txDataPolarity <= wbyte[INV_BIT];
          cfg_r[dec.ch].txSampleEdgeSelect <= wbyte[EDGE_BIT];
          cfg_r[dec.ch].txEncoderMode <= wbyte[MODE_LO+:2];
        end
        default: ;
      endcase
    end
  end

  // decoded controls for the transmit path of each channel
  always_ff @(posedge clock) begin
    for (int i = 0; i < Channels; i++) begin
      if (!rst_n) begin
        txCtrl[i] <= '0;
        txCtrl[i].encoder <= ENC_HDB3;
      end else begin
        txCtrl[i].encoder <= pickEncoder(cfg_r[i]); // RQ14 RQ15
        txCtrl[i].powerDown <= cfg_r[i].txOff; // RQ11
        txCtrl[i].driverOe <= !cfg_r[i].txOff; // RQ11
        txCtrl[i].invert <= cfg_r[i].txDataPolarity; // RQ12
        txCtrl[i].riseEdge <= cfg_r[i].txSampleEdgeSelect; // RQ13
        txCtrl[i].dualRail <= cfg_r[i].txEncoderMode[1]; // RQ14
        txCtrl[i].attenInPath <= cfg_r[i].txAttenuatorEnable; // RQ8
        txCtrl[i].wideLimit <= cfg_r[i].wideBandLimit; // RQ7
        txCtrl[i].lineT1 <= cfg_r[i].lineStandardBit; // RQ5
        case (cfg_r[i].txAttenuatorDepth)
          2'b00: txCtrl[i].depthBits <= DEPTH_128; // RQ9
          2'b01: txCtrl[i].depthBits <= DEPTH_64; // RQ9
          default: txCtrl[i].depthBits <= DEPTH_32; // RQ9
        endcase
        case ({cfg_r[i].txAttenuatorBandwidth, cfg_r[i].lineStandardBit})
          2'b00: txCtrl[i].cornerCentiHz <= CORNER_E1_NARROW; // RQ10
          2'b01: txCtrl[i].cornerCentiHz <= CORNER_T1_NARROW; // RQ10
          2'b10: txCtrl[i].cornerCentiHz <= CORNER_E1_WIDE; // RQ10
          default: txCtrl[i].cornerCentiHz <= CORNER_T1_WIDE; // RQ10
        endcase
      end
    end
  end

  // jitter measurement: live value or peak-to-peak since the last read
  always_ff @(posedge clock) begin
    for (int i = 0; i < Channels; i++) begin
      if (!rst_n) begin
        jitValue_r[i] <= 8'h00;
        jitMin_r[i] <= 8'h00;
        jitMax_r[i] <= 8'h00;
        jitEmpty_r[i] <= 1'b1;
      end else if (!cfg_r[i].jitterMeasureMode) begin
        jitEmpty_r[i] <= 1'b1;
        if (jitValid[i]) begin
          jitValue_r[i] <= jitSample[i]; // RQ6
        end
      end else begin
        if (rdEn && dec.isChan && dec.low == IDX_JIT_MEAS && 3'(i) == dec.ch) begin
          // a read restarts the window; a sample in the same cycle opens it
          jitEmpty_r[i] <= !jitValid[i];
          jitMin_r[i] <= jitSample[i];
          jitMax_r[i] <= jitSample[i];
          jitValue_r[i] <= 8'h00; // RQ6
        end else if (jitValid[i]) begin
          jitEmpty_r[i] <= 1'b0;
          if (jitEmpty_r[i]) begin
            jitMin_r[i] <= jitSample[i];
            jitMax_r[i] <= jitSample[i];
            jitValue_r[i] <= 8'h00;
          end else begin
            if (jitSample[i] < jitMin_r[i]) begin
              jitMin_r[i] <= jitSample[i];
            end
            if (jitSample[i] > jitMax_r[i]) begin
              jitMax_r[i] <= jitSample[i];
            end
            jitValue_r[i] <= ((jitSample[i] > jitMax_r[i]) ? jitSample[i] : jitMax_r[i]) -
                             ((jitSample[i] < jitMin_r[i]) ? jitSample[i] : jitMin_r[i]); // RQ6
          end
        end
      end
    end
  end

  // two flip-flop synchronisers for the transmit clock and data pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clkMeta_r <= '0;
      clkSync_r <= '0;
      clkPrev_r <= '0;
      dataMeta_r <= '0;
      dataSync_r <= '0;
    end else begin
      clkMeta_r <= txChannelClock;
      clkSync_r <= clkMeta_r;
      clkPrev_r <= clkSync_r;
      for (int i = 0; i < Channels; i++) begin
        dataMeta_r[i] <= {txNegativeRailIn[i], txPositiveRailIn[i], txSingleRailIn[i]};
      end
      dataSync_r <= dataMeta_r;
    end
  end

  // capture on the selected clock edge with polarity and rail format applied
  always_ff @(posedge clock) begin
    for (int i = 0; i < Channels; i++) begin
      if (!rst_n) begin
        txPosRail[i] <= 1'b0;
        txNegRail[i] <= 1'b0;
        txBitStrobe[i] <= 1'b0;
      end else begin
        txBitStrobe[i] <= 1'b0;
        if (!cfg_r[i].txOff && // RQ11
            (cfg_r[i].txSampleEdgeSelect ? (clkSync_r[i] && !clkPrev_r[i])
                                         : (!clkSync_r[i] && clkPrev_r[i]))) begin // RQ13
          txBitStrobe[i] <= 1'b1;
          if (cfg_r[i].txEncoderMode[1]) begin
            txPosRail[i] <= dataSync_r[i][1] ^ cfg_r[i].txDataPolarity; // RQ12 RQ14
            txNegRail[i] <= dataSync_r[i][2] ^ cfg_r[i].txDataPolarity; // RQ12 RQ14
          end else begin
            txPosRail[i] <= dataSync_r[i][0] ^ cfg_r[i].txDataPolarity; // RQ12 RQ14
            txNegRail[i] <= 1'b0;
          end
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_overflow;
    secTick;
  endsequence
  sequence s_flag_up;
    secondTimerOverflowFlag_r;
  endsequence
  property p_chan_flags;
    1'b1 |=> irqSourceChannelFlags_r == 8'($past(chanIrq));
  endproperty
  a_chan_flags: assert property (p_chan_flags) else $error("channel flags lag"); // RQ1
  property p_irq_mask;
    !secondTimerIrqEnable_r |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised"); // RQ2
  property p_overflow_irq;
    s_overflow ##1 (s_flag_up and secondTimerIrqEnable_r) |=> irq;
  endproperty
  a_overflow_irq: assert property (p_overflow_irq) else $error("overflow irq missing"); // RQ3
  property p_w1c;
    wrEn && !dec.isChan && paddr[LTC_AW-1:2] == IDX_TMR_STAT && wbyte[TMR_BIT] && !secTick
      |=> !secondTimerOverflowFlag_r;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared"); // RQ4
  property p_w0_keeps;
    secondTimerOverflowFlag_r && !(wrEn && wbyte[TMR_BIT]) |=> secondTimerOverflowFlag_r;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("flag lost"); // RQ4

  // per channel checks, one copy for every channel so each exercised channel is watched
  for (genvar g = 0; g < Channels; g++) begin : g_chk
    property p_encoder;
      1'b1 |=> txCtrl[g].encoder == $past(pickEncoder(cfg_r[g]));
    endproperty
    a_encoder: assert property (p_encoder) else $error("encoder select wrong"); // RQ14
    property p_depth;
      cfg_r[g].txAttenuatorDepth[1] |=> txCtrl[g].depthBits == DEPTH_32;
    endproperty
    a_depth: assert property (p_depth) else $error("depth decode wrong"); // RQ9
    property p_power_down;
      cfg_r[g].txOff |=> !txBitStrobe[g] && !txCtrl[g].driverOe;
    endproperty
    a_power_down: assert property (p_power_down) else $error("powered down channel active"); // RQ11
    property p_edge;
      txBitStrobe[g] |-> $past(clkSync_r[g]) != $past(clkPrev_r[g]) &&
        $past(clkSync_r[g]) == $past(cfg_r[g].txSampleEdgeSelect);
    endproperty
    a_edge: assert property (p_edge) else $error("wrong sampling edge"); // RQ13
    property p_realtime;
      !cfg_r[g].jitterMeasureMode && jitValid[g] |=> jitValue_r[g] == $past(jitSample[g]);
    endproperty
    a_realtime: assert property (p_realtime) else $error("live jitter stale"); // RQ6
  end

endmodule

// *** tb/ltc_regs_tb_top.sv ***
// self-checking bench for the line transmit configuration register bank
`timescale 1ns/1ps
module ltc_regs_tb_top import ltc_pkg::*;;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic rerr;
  logic irq;
  logic [7:0] chanIrq = 8'h00;
  logic [7:0][7:0] jitSample = '0;
  logic [7:0] jitValid = 8'h00;
  logic [7:0] txClk = 8'h00;
  logic [7:0] txSingle = 8'h00;
  logic [7:0] txPos = 8'h00;
  logic [7:0] txNeg = 8'h00;
  ltc_tx_ctrl_t [7:0] txCtrl;
  logic [7:0] txPosRail;
  logic [7:0] txNegRail;
  logic [7:0] txBitStrobe;
  int badCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  int strobes = 0;

  // short timer period keeps the run brief
  ltc_regs #(.SecCycles(400), .Channels(8)) DUT (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chanIrq(chanIrq), .jitSample(jitSample), .jitValid(jitValid),
    .txChannelClock(txClk), .txSingleRailIn(txSingle), .txPositiveRailIn(txPos),
    .txNegativeRailIn(txNeg), .irq(irq), .txCtrl(txCtrl), .txPosRail(txPosRail),
    .txNegRail(txNegRail), .txBitStrobe(txBitStrobe)
  );

  // clock generation
  initial begin
    forever #2.5 clock = ~clock;
  end

  // cycle count for the hang guard, strobe count on channel 1
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (txBitStrobe[1] === 1'b1) begin
      strobes <= strobes + 1;
    end
    if (cycles == 20000) begin
      badCount++;
      finalReport();
    end
  end

  // verdict and end of run
  task automatic finalReport();
    if (badCount == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // request held until a rising edge sees pready; the hang guard ends a lost answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string name, input logic [13:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(name, rdata, exp);
  endtask

  // byte address of a channel register
  function automatic logic [13:0] ca(input int k, input logic [7:0] i);
    return {4'(k + 1), i, 2'b00};
  endfunction

  task automatic pulse(input logic [7:0] v);
    jitSample[2] <= v;
    jitValid[2] <= 1'b1;
    @(posedge clock);
    jitValid[2] <= 1'b0;
    @(posedge clock);
  endtask

  // one transmit clock level change on channel 1 with data set a cycle ahead
  task automatic pin(input logic c, input logic d);
    txSingle[1] <= d;
    @(posedge clock);
    txClk[1] <= c;
    repeat (8) @(posedge clock);
  endtask

  // main sequence
  initial begin
    int n;
    int m;
    ltc_enc_t e;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    check("irqReset", irq, 32'h0);
    rd("chanFlags", 14'h024, 32'h0);
    rd("tmrStat", 14'h034, 32'h0);
    for (int k = 0; k < 8; k += 7) begin
      rd("attCfg", ca(k, IDX_ATT_CFG), 32'h10);
      rd("txCfg0", ca(k, IDX_TX_CFG0), 32'h0);
      rd("lineStd", ca(k, IDX_LINE_STD), 32'h0);
      check("encReset", txCtrl[k].encoder, ENC_HDB3);
      check("depthReset", txCtrl[k].depthBits, DEPTH_128);
      check("cornerReset", txCtrl[k].cornerCentiHz, CORNER_E1_NARROW);
      check("inPathReset", txCtrl[k].attenInPath, 32'h0);
    end
    // channel interrupt flags and refused accesses
    chanIrq <= 8'ha5;
    rd("chanFlags", 14'h024, 32'ha5);
    chanIrq <= 8'h5a;
    rd("chanFlags", 14'h024, 32'h5a);
    apb(1'b0, 14'h028, 32'h0);
    check("unmappedErr", rerr, 32'h1);
    apb(1'b1, 14'h025, 32'h1);
    check("misalignErr", rerr, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, ca(3, IDX_LINE_STD), 32'h1);
    pstrb <= 4'hf;
    rd("noStrobe", ca(3, IDX_LINE_STD), 32'h0);
    // timer: raise, write zero, write one, then masked
    apb(1'b1, 14'h030, 32'h1);
    rd("tmrEn", 14'h030, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    check("irqRise", irq, 32'h1);
    rd("tmrStat", 14'h034, 32'h1);
    apb(1'b1, 14'h034, 32'h0);
    rd("tmrStatKeep", 14'h034, 32'h1);
    apb(1'b1, 14'h034, 32'h1);
    rd("tmrStatClr", 14'h034, 32'h0);
    check("irqClr", irq, 32'h0);
    apb(1'b1, 14'h030, 32'h0);
    m = 0;
    repeat (420) begin
      @(posedge clock);
      if (irq !== 1'b0) m++;
    end
    check("irqMasked", 32'(m), 32'h0);
    rd("tmrStatMasked", 14'h034, 32'h1);
    // encoder, depth and corner tables on channel 4
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ca(4, IDX_LINE_STD), 32'(s));
      for (int md = 0; md < 4; md++) begin
        apb(1'b1, ca(4, IDX_TX_CFG0), 32'(md));
        repeat (2) @(posedge clock);
        e = md > 1 ? ENC_BYPASS : md == 1 ? ENC_AMI : s == 1 ? ENC_B8ZS : ENC_HDB3;
        check("enc", txCtrl[4].encoder, e);
        check("dual", txCtrl[4].dualRail, 32'(md > 1));
        check("lineT1", txCtrl[4].lineT1, 32'(s));
      end
      for (int v = 0; v < 8; v++) begin
        apb(1'b1, ca(4, IDX_ATT_CFG), 32'(v));
        repeat (2) @(posedge clock);
        check("depth", txCtrl[4].depthBits,
              v[2:1] == 0 ? DEPTH_128 : v[2:1] == 1 ? DEPTH_64 : DEPTH_32);
        check("corner", txCtrl[4].cornerCentiHz, v[0] ? (s ? CORNER_T1_WIDE : CORNER_E1_WIDE)
              : (s ? CORNER_T1_NARROW : CORNER_E1_NARROW));
        check("wideLim", txCtrl[4].wideLimit, 32'h0);
        check("inPath", txCtrl[4].attenInPath, 32'h0);
      end
    end
    apb(1'b1, ca(4, IDX_ATT_CFG), 32'h18);
    rd("attCfg", ca(4, IDX_ATT_CFG), 32'h18);
    check("inPathOn", txCtrl[4].attenInPath, 32'h1);
    check("wideLimOn", txCtrl[4].wideLimit, 32'h1);
    apb(1'b1, ca(4, IDX_TX_CFG0), 32'h1c);
    rd("txCfg0", ca(4, IDX_TX_CFG0), 32'h1c);
    check("ctl", {txCtrl[4].powerDown, txCtrl[4].driverOe, txCtrl[4].invert,
          txCtrl[4].riseEdge}, 32'hb);
    apb(1'b1, ca(4, IDX_TX_CFG0), 32'h00);
    repeat (2) @(posedge clock);
    check("ctlOff", {txCtrl[4].powerDown, txCtrl[4].driverOe, txCtrl[4].invert,
          txCtrl[4].riseEdge}, 32'h4);
    // jitter value, live then peak to peak on channel 2
    pulse(8'h33);
    rd("jitLive", ca(2, IDX_JIT_MEAS), 32'h33);
    apb(1'b1, ca(2, IDX_ATT_CFG), 32'h30);
    apb(1'b0, ca(2, IDX_JIT_MEAS), 32'h0);
    pulse(8'h10);
    pulse(8'h50);
    pulse(8'h20);
    rd("jitPeak", ca(2, IDX_JIT_MEAS), 32'h40);
    rd("jitRestart", ca(2, IDX_JIT_MEAS), 32'h0);
    // transmit pins on channel 1: edge, polarity, dual rail, power down
    apb(1'b1, ca(1, IDX_TX_CFG0), 32'h04);
    n = strobes;
    pin(1'b1, 1'b1);
    pin(1'b0, 1'b0);
    check("riseStrobes", 32'(strobes - n), 32'h1);
    check("railRise", {txPosRail[1], txNegRail[1]}, 32'h2);
    apb(1'b1, ca(1, IDX_TX_CFG0), 32'h08);
    pin(1'b1, 1'b1);
    pin(1'b0, 1'b1);
    check("fallStrobes", 32'(strobes - n), 32'h2);
    check("railInv", {txPosRail[1], txNegRail[1]}, 32'h0);
    apb(1'b1, ca(1, IDX_TX_CFG0), 32'h02);
    txNeg[1] <= 1'b1;
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    check("railDual", {txPosRail[1], txNegRail[1]}, 32'h1);
    apb(1'b1, ca(1, IDX_TX_CFG0), 32'h10);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    check("offStrobes", 32'(strobes - n), 32'h3);
    finalReport();
  end
endmodule
